// ---- src/bfg_pkg.sv ----
// package for the boot flash self-program guard: widths, encodings, timing
// assumes a single 40 MHz system clock and word-addressed program flash
package bfg_pkg;

  // -------------------------------------------------------------------------
  // address layout
  // -------------------------------------------------------------------------
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned SIZE_W        = 2;
  localparam logic [ADDR_W-1:0] STALL_START = 16'hF000;
  // loader sizes in words, chosen by the loader_size_fuses code
  localparam logic [ADDR_W-1:0] LOADER_WORDS_0 = 16'h1000;
  localparam logic [ADDR_W-1:0] LOADER_WORDS_1 = 16'h0800;
  localparam logic [ADDR_W-1:0] LOADER_WORDS_2 = 16'h0400;
  localparam logic [ADDR_W-1:0] LOADER_WORDS_3 = 16'h0200;

  // -------------------------------------------------------------------------
  // lock encodings (1 = unprogrammed)
  // -------------------------------------------------------------------------
  localparam logic [1:0] LOCK_MODE1 = 2'h3;
  localparam logic [1:0] LOCK_MODE2 = 2'h2;
  localparam logic [1:0] LOCK_MODE3 = 2'h0;
  localparam logic [1:0] LOCK_MODE4 = 2'h1;
  localparam logic [1:0] GEN_NONE   = 2'h3;
  localparam logic [1:0] GEN_WLOCK  = 2'h2;
  localparam logic [1:0] GEN_RWLOCK = 2'h0;
  localparam logic [5:0] LOCK_RESET = 6'h3F;

  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int unsigned CLK_NS      = 25;
  localparam int unsigned PROG_US     = 4;
  localparam int unsigned PROG_CYCLES = (PROG_US * 1000) / CLK_NS;
  localparam int unsigned CNT_W       = 16;

  typedef struct packed {
    logic [1:0] general;
    logic [1:0] app;
    logic [1:0] loader;
  } bfg_lock_t;

  typedef enum logic [1:0] {
    BFG_IDLE,
    BFG_PROG_CONC,
    BFG_PROG_STALL
  } bfg_state_t;

  typedef struct packed {
    bfg_state_t        st;
    logic [CNT_W-1:0]  cnt;
    logic              busy;
    logic              spm_en;
    bfg_lock_t         lock;
    logic              st_ok;
    logic              ld_ok;
  } bfg_regs_t;

endpackage

// ---- src/bfg_guard.sv ----
// boot flash self-program guard: region decode, lock checks, stall control
// assumes the cpu presents pc and target address with one-cycle strobes
// ---------------------------------------------------------------------------
// Functional notes
// - stores issued from the application region are ignored.
// - stores from the loader region may target any flash address.
// - stall versus run follows the target page region, not the fetch.
// - programming concurrent-read region: cpu runs, reads stall region only.
// - programming stall region: cpu halted, no region readable.
// - loader region always sits inside the stall region.
// - region busy flag is one while concurrent-read region is blocked.
// - lock bits only get programmed; chip erase or system reset restores them.
// - general write lock refuses every store.
// - general read/write lock refuses loads and stores.
// - application lock mode 1 leaves application accesses unrestricted.
// - application mode 2 blocks stores to application, loads allowed.
// - application mode 3 blocks stores and loader loads of application.
// - application mode 4 allows stores, blocks loader loads of application.
// - application modes 3/4 mask interrupts in application if vectors loader.
// - loader lock mode 1 leaves loader accesses unrestricted.
// - loader mode 2 blocks stores into the loader region.
// - loader mode 3 blocks stores and application loads of loader.
// - loader mode 4 allows stores, blocks application loads of loader.
// - loader modes 3/4 mask interrupts in loader if vectors application.
// - self-program interrupt stays asserted while enable bit is clear.
module bfg_guard
  import bfg_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_ce,
  input  wire logic [SIZE_W-1:0] i_loader_size_fuses,
  input  wire logic [ADDR_W-1:0] i_pc,
  input  wire logic              i_store_req,
  input  wire logic              i_load_req,
  input  wire logic [ADDR_W-1:0] i_target_addr,
  input  wire logic              i_fetch_req,
  input  wire logic [ADDR_W-1:0] i_fetch_addr,
  input  wire logic              i_lock_wr,
  input  wire bfg_lock_t         i_lock_wdata,
  input  wire logic              i_chip_erase,
  input  wire logic              i_busy_clr,
  input  wire logic              i_vectors_in_loader,
  input  wire logic              i_spm_irq_en,
  input  wire logic              i_irq_req,
  output logic                   o_store_ok,
  output logic                   o_load_ok,
  output logic                   o_prog_start,
  output logic                   o_cpu_halt,
  output logic                   o_read_ok,
  output logic                   o_region_busy_flag,
  output logic                   o_self_program_enable_bit,
  output logic                   o_irq_allow,
  output logic                   o_spm_irq,
  output bfg_lock_t              o_lock
);

  // ---------------------------------------------------------------------------
  // region decode
  // ---------------------------------------------------------------------------
  logic [ADDR_W-1:0] loader_words;
  logic [ADDR_W-1:0] loader_start;
  always_comb begin
    case (i_loader_size_fuses)
      2'h0:    loader_words = LOADER_WORDS_0;
      2'h1:    loader_words = LOADER_WORDS_1;
      2'h2:    loader_words = LOADER_WORDS_2;
      default: loader_words = LOADER_WORDS_3;
    endcase
  end
  // loader sits at the top of flash and is never larger than the stall part
  assign loader_start = ADDR_W'(16'h0000 - loader_words);

  logic pc_in_loader;
  logic tgt_in_loader;
  logic tgt_in_stall;
  logic fetch_in_stall;
  assign pc_in_loader   = (i_pc >= loader_start);
  assign tgt_in_loader  = (i_target_addr >= loader_start);
  assign tgt_in_stall   = (i_target_addr >= STALL_START);
  assign fetch_in_stall = (i_fetch_addr >= STALL_START);

  bfg_regs_t r;
  bfg_regs_t nxt;

  // ---------------------------------------------------------------------------
  // lock checks
  // ---------------------------------------------------------------------------
  logic app_st_blk;
  logic app_ld_blk;
  logic ldr_st_blk;
  logic ldr_ld_blk;
  logic gen_st_blk;
  logic gen_ld_blk;
  logic store_ok;
  logic load_ok;

  // mode 1 decodes to no block at all
  assign app_st_blk = (r.lock.app == LOCK_MODE2)
                   || (r.lock.app == LOCK_MODE3);
  assign app_ld_blk = (r.lock.app == LOCK_MODE3)
                   || (r.lock.app == LOCK_MODE4);
  assign ldr_st_blk = (r.lock.loader == LOCK_MODE2)
                   || (r.lock.loader == LOCK_MODE3);
  assign ldr_ld_blk = (r.lock.loader == LOCK_MODE3)
                   || (r.lock.loader == LOCK_MODE4);
  assign gen_st_blk = (r.lock.general == GEN_WLOCK)
                   || (r.lock.general == GEN_RWLOCK);
  assign gen_ld_blk = (r.lock.general == GEN_RWLOCK);

  always_comb begin
    store_ok = i_store_req && pc_in_loader && !gen_st_blk
            && (r.st == BFG_IDLE)
            && !(tgt_in_loader ? ldr_st_blk : app_st_blk);
    load_ok  = i_load_req && !gen_ld_blk && (r.st != BFG_PROG_STALL)
            && !(!tgt_in_stall && r.busy);
    // only cross-region loads are subject to the region read locks
    if (pc_in_loader && !tgt_in_loader && app_ld_blk) begin
      load_ok = 1'b0;
    end
    if (!pc_in_loader && tgt_in_loader && ldr_ld_blk) begin
      load_ok = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // state update
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt       = r;
    nxt.st_ok = store_ok;
    nxt.ld_ok = load_ok;
    // locks may only move toward programmed; erase restores all ones
    if (i_chip_erase) begin
      nxt.lock = LOCK_RESET;
    end else if (i_lock_wr && r.st == BFG_IDLE) begin
      nxt.lock = r.lock & i_lock_wdata;
    end
    case (r.st)
      BFG_IDLE: begin
        if (store_ok) begin
          nxt.spm_en = 1'b1;
          nxt.cnt    = CNT_W'(PROG_CYCLES - 1);
          if (tgt_in_stall) begin
            nxt.st = BFG_PROG_STALL;
          end else begin
            nxt.st   = BFG_PROG_CONC;
            nxt.busy = 1'b1;
          end
        end else if (i_busy_clr) begin
          nxt.busy = 1'b0;
        end
      end
      BFG_PROG_CONC,
      BFG_PROG_STALL: begin
        if (r.cnt == '0) begin
          nxt.st     = BFG_IDLE;
          nxt.spm_en = 1'b0;
        end else begin
          nxt.cnt = r.cnt - CNT_W'(1);
        end
      end
      default: nxt.st = BFG_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      r.st     <= BFG_IDLE;
      r.cnt    <= '0;
      r.busy   <= 1'b0;
      r.spm_en <= 1'b0;
      r.lock   <= LOCK_RESET;
      r.st_ok  <= 1'b0;
      r.ld_ok  <= 1'b0;
    end else if (i_ce) begin
      r <= nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  logic irq_mask;
  // with vectors in one region, interrupts must not fire in the other while its lock is mode 3 or 4
  assign irq_mask = (i_vectors_in_loader && !pc_in_loader && app_ld_blk)
                 || (!i_vectors_in_loader && pc_in_loader && ldr_ld_blk);

  assign o_store_ok   = r.st_ok;
  assign o_load_ok    = r.ld_ok;
  assign o_prog_start = r.st_ok;
  assign o_cpu_halt   = (r.st == BFG_PROG_STALL);
  // blocked concurrent-read reads would corrupt fetch, so they are refused
  assign o_read_ok    = i_fetch_req && (r.st != BFG_PROG_STALL)
                     && (fetch_in_stall || !r.busy);
  assign o_region_busy_flag        = r.busy;
  assign o_self_program_enable_bit = r.spm_en;
  assign o_irq_allow  = i_irq_req && !irq_mask;
  assign o_spm_irq    = i_spm_irq_en && !r.spm_en;
  assign o_lock       = r.lock;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_app_store_ignored: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_ce && i_store_req && !pc_in_loader |=> !o_store_ok)
    else $error("store from application region accepted");

  a_stall_halts_cpu: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_ce && store_ok && tgt_in_stall |=> o_cpu_halt && !o_read_ok)
    else $error("stall region program did not halt");

  a_conc_runs_cpu: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_ce && store_ok && !tgt_in_stall |=> !o_cpu_halt && o_region_busy_flag)
    else $error("concurrent region program halted cpu");

  a_busy_blocks_read: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    o_region_busy_flag && i_fetch_req && !fetch_in_stall |-> !o_read_ok)
    else $error("read of busy region allowed");

  a_gen_wlock_store: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_ce && r.lock.general == GEN_WLOCK && i_store_req |=> !o_store_ok)
    else $error("store passed under write lock");

  a_gen_rwlock_load: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_ce && r.lock.general == GEN_RWLOCK && i_load_req |=> !o_load_ok)
    else $error("load passed under read write lock");

  a_lock_only_sets: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_ce && !i_chip_erase |=> (o_lock & ~$past(o_lock)) == '0)
    else $error("lock bit returned unprogrammed without erase");

  a_app_store_lock: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_ce && r.lock.app == LOCK_MODE2 && i_store_req && !tgt_in_loader
    |=> !o_store_ok)
    else $error("application store passed mode 2");

  a_ldr_load_lock: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_ce && r.lock.loader == LOCK_MODE4 && i_load_req && !pc_in_loader
    && tgt_in_loader |=> !o_load_ok)
    else $error("loader read passed mode 4");

  a_spm_irq_level: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_ce && r.spm_en && r.cnt == '0 |=> o_spm_irq == i_spm_irq_en)
    else $error("self program interrupt not asserted");

  a_app_mode3_store: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_ce && r.lock.app == LOCK_MODE3 && i_store_req && !tgt_in_loader
    |=> !o_store_ok)
    else $error("application store passed mode 3");

  a_app_mode4_load: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_ce && r.lock.app == LOCK_MODE4 && i_load_req && pc_in_loader
    && !tgt_in_loader |=> !o_load_ok)
    else $error("application read passed mode 4");

  a_app_open_store: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_ce && i_store_req && pc_in_loader && !tgt_in_loader
    && r.lock.app == LOCK_MODE1 && r.lock.general == GEN_NONE
    && r.st == BFG_IDLE |=> o_store_ok)
    else $error("unlocked application store refused");

  a_ldr_mode2_store: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_ce && r.lock.loader == LOCK_MODE2 && i_store_req && tgt_in_loader
    |=> !o_store_ok)
    else $error("loader store passed mode 2");

  a_ldr_mode3_load: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_ce && r.lock.loader == LOCK_MODE3 && i_load_req && !pc_in_loader
    && tgt_in_loader |=> !o_load_ok)
    else $error("loader read passed mode 3");

  a_irq_mask_app: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_vectors_in_loader && !pc_in_loader && r.lock.app == LOCK_MODE3
    |-> !o_irq_allow)
    else $error("interrupt taken in locked application region");

  a_irq_mask_ldr: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !i_vectors_in_loader && pc_in_loader && r.lock.loader == LOCK_MODE4
    |-> !o_irq_allow)
    else $error("interrupt taken in locked loader region");

  a_erase_restores: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_ce && i_chip_erase |=> o_lock == LOCK_RESET)
    else $error("chip erase left a lock bit programmed");

  a_stall_no_load: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_ce && o_cpu_halt && i_load_req |=> !o_load_ok)
    else $error("load passed while cpu halted");

  a_conc_busy_holds: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_ce && r.st == BFG_PROG_CONC |=> o_region_busy_flag)
    else $error("busy flag dropped during programming");

endmodule

// ---- dv/bfg_cpu_model.sv ----
// cpu core model: drives program-memory stores, loads and fetches
// assumes the bench calls its tasks at a falling clock edge
module bfg_cpu_model
  import bfg_pkg::*;
(
  input  wire logic              i_clk,
  output logic                   o_store_req,
  output logic                   o_load_req,
  output logic [ADDR_W-1:0]      o_pc,
  output logic [ADDR_W-1:0]      o_target_addr,
  output logic                   o_fetch_req,
  output logic [ADDR_W-1:0]      o_fetch_addr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_store_req   = 1'b0;
    o_load_req    = 1'b0;
    o_pc          = 16'h0000;
    o_target_addr = 16'h0000;
    o_fetch_req   = 1'b1;
    o_fetch_addr  = STALL_START;
  end

  // one-cycle request; the released target address shows its inverse, not stale data, while pc holds
  task automatic access(input logic st, input logic [ADDR_W-1:0] pc, t);
    o_pc          = pc;
    o_target_addr = t;
    o_store_req   = st;
    o_load_req    = !st;
    @(negedge i_clk);
    o_store_req   = 1'b0;
    o_load_req    = 1'b0;
    o_target_addr = ~t;
  endtask

  // only moves the fetch address; o_fetch_req stays high, so the last probed address, often concurrent-region, keeps being fetched
  task automatic fetch(input logic [ADDR_W-1:0] a);
    o_fetch_addr = a;
  endtask
endmodule

// ---- dv/tb_top.sv ----
// bench for the self-program guard: random locks, stores, loads, fetches
// assumes the cpu model sits on the request side; one 40 MHz clock
module tb_top
  import bfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk, rst, ce, lwr, erase, bclr, vec, irq_en, irq, bz;
  logic [SIZE_W-1:0] size;
  bfg_lock_t         lwd, lk, lock_o;
  logic              st_req, ld_req, freq, st_ok, ld_ok, pstart, halt;
  logic              rd_ok, busy, spme, irq_ok, spm_irq;
  logic [ADDR_W-1:0] pc, tgt, fa, p, t;
  logic [1:0]        gtab [3] = '{GEN_NONE, GEN_WLOCK, GEN_RWLOCK};
  int                errors, n_tests, cyc;

  bfg_cpu_model cpu_u (.i_clk(clk), .o_store_req(st_req),
    .o_load_req(ld_req), .o_pc(pc), .o_target_addr(tgt),
    .o_fetch_req(freq), .o_fetch_addr(fa));

  bfg_guard dut_u (.i_clk(clk), .i_sys_rst(rst), .i_ce(ce),
    .i_loader_size_fuses(size), .i_pc(pc), .i_store_req(st_req),
    .i_load_req(ld_req), .i_target_addr(tgt), .i_fetch_req(freq),
    .i_fetch_addr(fa), .i_lock_wr(lwr), .i_lock_wdata(lwd),
    .i_chip_erase(erase), .i_busy_clr(bclr), .i_vectors_in_loader(vec),
    .i_spm_irq_en(irq_en), .i_irq_req(irq), .o_store_ok(st_ok),
    .o_load_ok(ld_ok), .o_prog_start(pstart), .o_cpu_halt(halt),
    .o_read_ok(rd_ok), .o_region_busy_flag(busy),
    .o_self_program_enable_bit(spme), .o_irq_allow(irq_ok),
    .o_spm_irq(spm_irq), .o_lock(lock_o));

  // ---------------------------------------------------------------------
  // expectations
  // ---------------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] ls();
    return 16'h0000 - (LOADER_WORDS_0 >> size);
  endfunction
  function automatic logic wlk(input logic [1:0] l);
    return l == LOCK_MODE2 || l == LOCK_MODE3;
  endfunction
  function automatic logic rlk(input logic [1:0] l);
    return l == LOCK_MODE3 || l == LOCK_MODE4;
  endfunction
  function automatic logic e_st(input logic [ADDR_W-1:0] a, b);
    return a >= ls() && lk.general == GEN_NONE
      && !wlk(b >= ls() ? lk.loader : lk.app);
  endfunction
  function automatic logic e_ld(input logic [ADDR_W-1:0] a, b);
    return lk.general != GEN_RWLOCK && !(b < STALL_START && bz)
      && !(a < ls() && b >= ls() && rlk(lk.loader))
      && !(a >= ls() && b < ls() && rlk(lk.app));
  endfunction
  function automatic logic e_irq(input logic [ADDR_W-1:0] a);
    return irq && !(rlk(lk.app) && vec && a < ls())
      && !(rlk(lk.loader) && !vec && a >= ls());
  endfunction

  task automatic chk(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // walks one accepted program operation; stall choice follows target
  task automatic prog(input logic [ADDR_W-1:0] b);
    int   n;
    logic s;
    s  = b >= STALL_START;
    bz = !s;
    n  = 0;
    while (spme === 1'b1 && n < 400) begin
      cpu_u.fetch(16'(n * 16'h0BCD));
      #1 chk({halt, busy, rd_ok}, {s, !s, !s && fa >= STALL_START});
      if (n == 5) begin
        cpu_u.access(1'b1, 16'hFFFF, b);
        chk(st_ok, 1'b0);
        n++;
      end
      @(negedge clk);
      n++;
    end
    chk(16'(n), 16'(PROG_CYCLES));
    chk({halt, spm_irq}, {1'b0, irq_en});
    if (!s) begin
      cpu_u.fetch(16'h0100);
      #1 chk(rd_ok, 1'b0);
      cpu_u.access(1'b0, 16'hFFFF, 16'h0123);
      chk(ld_ok, e_ld(16'hFFFF, 16'h0123));
      bclr = 1'b1;
      @(negedge clk);
      bclr = 1'b0;
      bz   = 1'b0;
      chk(busy, 1'b0);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      results();
    end
  end

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    {rst, lwr, erase, bclr, vec, irq_en, irq, bz} = 8'h80;
    ce   = 1'b1;
    size = 2'h0;
    lwd  = LOCK_RESET;
    lk   = LOCK_RESET;
    void'($urandom(32'h7A5D));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk({lock_o, busy, spme}, {LOCK_RESET, 2'h0});
    // clock enable low must freeze the lock state against a write
    ce  = 1'b0;
    lwr = 1'b1;
    lwd = '0;
    @(negedge clk);
    ce  = 1'b1;
    lwr = 1'b0;
    lwd = LOCK_RESET;
    chk(lock_o, LOCK_RESET);
    for (int i = 0; i < 60; i++) begin
      {size, vec, irq_en, irq} = 5'($urandom);
      erase = 1'b1;
      @(negedge clk);
      erase = 1'b0;
      lwr   = 1'b1;
      lwd   = (i % 4 == 0) ? LOCK_RESET : {gtab[$urandom % 3], 4'($urandom)};
      lk    = lwd;
      @(negedge clk);
      lwd   = LOCK_RESET;
      @(negedge clk);
      lwr   = 1'b0;
      chk(lock_o, lk);
      p = 16'($urandom) | (i[0] ? 16'hFE00 : 16'h0000);
      t = 16'($urandom) | (i[1] ? 16'hF000 : 16'h0000);
      cpu_u.access(1'b0, p, t);
      chk({ld_ok, irq_ok}, {e_ld(p, t), e_irq(p)});
      cpu_u.access(1'b1, p, t);
      chk({st_ok, pstart}, {2{e_st(p, t)}});
      if (e_st(p, t))
        prog(t);
      $display("test %0d done", i);
    end
    results();
  end
endmodule
